// ---- common/line_mon_pkg.sv ----
// constants, field layouts and carriers of the receive line overhead monitor
// assumes one receive byte clock shared with the upstream section processor
//
// Function
// RULE_01: remote defect state bit readable
// RULE_02: alarm indication state bit readable
// RULE_03: report mode: once per frame or per bit
// RULE_04: report mode leaves counter accumulation alone
// RULE_05: remote defect after 3 or 5 frames
// RULE_06: alarm indication after 3 or 5 frames
// RULE_07: force ones while alarm declared, enabled
// RULE_08: force disabled: input data passes through
// RULE_09: counting mode: once per frame or per bit
// RULE_10: remote defect change flag, clear on read
// RULE_11: alarm indication change flag, clear on read
// RULE_12: b2 error flag, clear on read
// RULE_13: far end error flag, clear on read
// RULE_14: remote defect change interrupt when enabled
// RULE_15: alarm indication change interrupt when enabled
// RULE_16: b2 error interrupt when enabled
// RULE_17: far end error interrupt when enabled
// RULE_18: 20-bit b2 count in three bytes
// RULE_19: count register write latches and restarts counts
// RULE_20: master register write latches all counts
// RULE_21: 20-bit far end error count, same poll
// RULE_22: interrupt while enabled flag set
package line_mon_pkg;

  // ----------------------------------------------------------------------
  // register map: indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          IDX_W           = 6;
  localparam logic [IDX_W-1:0] IDX_MASTER    = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 6'h18;
  localparam logic [IDX_W-1:0] IDX_IRQ       = 6'h19;
  localparam logic [IDX_W-1:0] IDX_B2_LO     = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_B2_MID    = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_B2_HI     = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_FE_LO     = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_FE_MID    = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_FE_HI     = 6'h1f;

  // ----------------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------------
  localparam int          FLAG_RDI        = 0;
  localparam int          FLAG_AIS        = 1;
  localparam int          FLAG_B2         = 2;
  localparam int          FLAG_FE         = 3;
  localparam int          NFLAGS          = 4;
  localparam logic [2:0]  K2_RDI_CODE     = 3'h6;
  localparam logic [2:0]  K2_AIS_CODE     = 3'h7;
  localparam logic [2:0]  RUN_FAST        = 3'h3;
  localparam logic [2:0]  RUN_SLOW        = 3'h5;
  localparam logic [3:0]  FEBE_MAX        = 4'h8;
  localparam logic [7:0]  ALL_ONES        = 8'hff;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------------
  // timing: poll transfer must land inside this time
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          POLL_MAX_NS     = 7000;
  localparam int          POLL_MAX_CYC    = POLL_MAX_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       b2_counting_mode;
    logic       force_ones_on_alarm;
    logic       alarm_indication_detect_select;
    logic       remote_defect_detect_select;
    logic       outgoing_error_report_mode;
  } ctrl_t;

  typedef struct packed {
    logic       sof;
    logic       k2_strobe;
    logic       b2_strobe;
    logic       z2_strobe;
    logic [7:0] b2_mismatch;
    logic [7:0] data;
  } line_in_t;

  typedef struct packed {
    logic       sof;
    logic [7:0] data;
  } line_out_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] count;
  } febe_report_t;

endpackage

// ---- sim/line_mon_assertions.sv ----
// concurrent checks on the ports of the receive line overhead monitor
// assumes one clock domain; bound after the endmodule
`timescale 1ns/100ps
module line_mon_assertions (
  input wire logic                          i_mclk,
  input wire logic                          i_reset,
  input wire line_mon_pkg::line_in_t        i_line,
  input wire line_mon_pkg::line_out_t       o_line,
  input wire line_mon_pkg::febe_report_t    o_febe_rep,
  input wire logic                          o_irq,
  input wire logic                          i_awvalid,
  input wire logic                          o_awready,
  input wire logic                          i_wvalid,
  input wire logic                          o_wready,
  input wire logic                          o_bvalid,
  input wire logic [line_mon_pkg::ADDR_W-1:0] i_araddr,
  input wire logic                          i_arvalid,
  input wire logic                          o_arready,
  input wire logic [1:0]                    o_rresp,
  input wire logic                          o_rvalid
);
  import line_mon_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // anything that may set a flag or enable
  wire logic ev = i_line.k2_strobe | i_line.b2_strobe | i_line.z2_strobe | (i_wvalid & o_wready);
  // ----------------------------------------------------------------------
  // stream and report
  // ----------------------------------------------------------------------
  line_delay_a: assert property (!$past(i_reset) |-> o_line.sof == $past(i_line.sof) &&
    (o_line.data == $past(i_line.data) || o_line.data == ALL_ONES))
    else $error("stream not delayed input");
  report_cause_a: assert property (o_febe_rep.valid |->
    $past(i_line.b2_strobe) && $past(i_line.b2_mismatch) != 8'h00)
    else $error("report without b2 error");
  report_count_a: assert property (o_febe_rep.valid |-> o_febe_rep.count == 4'h1 ||
    o_febe_rep.count == $countones($past(i_line.b2_mismatch)))
    else $error("report count wrong");
  report_quiet_a: assert property (i_line.b2_strobe && i_line.b2_mismatch == 8'h00 |=>
    !o_febe_rep.valid)
    else $error("report for clean b2");
  // ----------------------------------------------------------------------
  // interrupt and register bus
  // ----------------------------------------------------------------------
  irq_cause_a: assert property ($rose(o_irq) |->
    $past(ev) || $past(ev, 2) || $past(ev, 3) || $past(ev, 4))
    else $error("irq rose without cause");
  irq_clear_a: assert property (i_arvalid && o_arready && i_araddr == 8'h64 &&
    !ev ##1 !ev ##1 !ev |-> ##[0:2] !o_irq)
    else $error("irq not cleared by read");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("late read data");
  write_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |->
    ##[1:3] o_bvalid)
    else $error("write response missing");
  unmapped_read_a: assert property (i_arvalid && o_arready && i_araddr == 8'h04 |=>
    o_rresp == RESP_SLVERR)
    else $error("unmapped read accepted");
  cover property (o_febe_rep.valid);
  cover property ($rose(o_irq));
  cover property (o_line.data == ALL_ONES && $past(i_line.data) != ALL_ONES);
endmodule // line_mon_assertions

bind line_overhead_monitor line_mon_assertions u_line_mon_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_line(i_line), .o_line(o_line),
  .o_febe_rep(o_febe_rep), .o_irq(o_irq), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_araddr(i_araddr),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rresp(o_rresp), .o_rvalid(o_rvalid)
);

// ---- sim/section_source_model.sv ----
// upstream section processor model: sends one frame per go pulse
// assumes the bench gives filler bytes that change every cycle
`timescale 1ns/100ps
module section_source_model #(
  parameter int FRAME_LEN = 8
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  input  wire logic                   i_go,
  input  wire logic [2:0]             i_k2_code,
  input  wire logic [7:0]             i_b2_mask,
  input  wire logic [3:0]             i_z2_count,
  input  wire logic [7:0]             i_fill,
  output logic                        o_busy,
  output line_mon_pkg::line_in_t      o_line
);
  import line_mon_pkg::*;
  logic [7:0] pos_r;
  assign o_busy = (pos_r != 8'h00);
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pos_r  <= 8'h00;
      o_line <= '0;
    end else begin
      o_line      <= '0;
      o_line.data <= i_fill;
      if (i_go || pos_r != 8'h00) begin
        pos_r      <= (pos_r == FRAME_LEN - 1) ? 8'h00 : pos_r + 8'h01;
        o_line.sof <= (pos_r == 8'h00);
        if (pos_r == 8'h02) begin
          o_line.k2_strobe   <= 1'b1;
          o_line.data[2:0]   <= i_k2_code;
        end
        if (pos_r == 8'h04) begin
          o_line.b2_strobe   <= 1'b1;
          o_line.b2_mismatch <= i_b2_mask;
        end
        if (pos_r == 8'h06) begin
          o_line.z2_strobe   <= 1'b1;
          o_line.data[3:0]   <= i_z2_count;
        end
      end
    end
  end
endmodule // section_source_model

// ---- sim/testbench.sv ----
// self-checking bench for the receive line overhead monitor
// assumes the source model and bound checker are compiled first
`timescale 1ns/100ps
module testbench;
  import line_mon_pkg::*;
  logic              i_mclk = 1'b0, i_reset = 1'b1, go = 1'b0, mon_on = 1'b0, forced = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [2:0]        k2 = 3'h0, kc;
  logic [3:0]        z2 = 4'h0;
  logic [7:0]        mask = 8'h00, m8, awaddr = 8'h00, araddr = 8'h00, prev_data = 8'h00;
  logic [31:0]       wdata = 32'h0, stim = 32'h0b5b, rnd = 32'h0b5b, d;
  logic [1:0]        r;
  logic [7:0]        cnt [6];
  logic [7:0]        polls [4] = '{8'h00, 8'h68, 8'h74, 8'h7c};
  wire logic         busy, awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  line_in_t          line_in;
  line_out_t         line_out;
  febe_report_t      rep;
  int                num_errors = 0, checks = 0, cyc = 0, rep_sum = 0, eb, er, ef, base, need;
  always #10 i_mclk = ~i_mclk;
  section_source_model src (.i_mclk(i_mclk), .i_reset(i_reset), .i_go(go), .i_k2_code(k2),
    .i_b2_mask(mask), .i_z2_count(z2), .i_fill(stim[7:0]), .o_busy(busy), .o_line(line_in));
  line_overhead_monitor dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_line(line_in),
    .o_line(line_out), .o_febe_rep(rep), .o_irq(irq), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(1'b1));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction
  function automatic int exp_b2(input logic mode, input logic [7:0] m);
    return (m == 8'h00) ? 0 : (mode ? 1 : $countones(m));
  endfunction
  function automatic int exp_fe(input logic [3:0] z);
    return (z <= FEBE_MAX) ? int'(z) : 0;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // write: aw and w offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ad = 1'b0, wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge i_mclk);
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    do @(posedge i_mclk); while (bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge i_mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic frame(input logic [2:0] k, input logic [7:0] m, input logic [3:0] z);
    k2 <= k;
    mask <= m;
    z2 <= z;
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    do @(posedge i_mclk); while (busy);
    repeat (2) @(posedge i_mclk);
  endtask
  // ----------------------------------------------------------------------
  // stream monitor, report tally and hang guard
  // ----------------------------------------------------------------------
  always @(posedge i_mclk) begin
    stim <= lfsr(stim);
    prev_data <= line_in.data;
    cyc <= cyc + 1;
    if (rep.valid === 1'b1) rep_sum = rep_sum + int'(rep.count);
    if (mon_on) check(line_out.data, forced ? ALL_ONES : prev_data, "downstream byte");
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      rd(8'h60 + 8'(4 * i));
      check(d, 32'h0, "reset value");
    end
    rd(8'h04);
    check(r, RESP_SLVERR, "unmapped read");
    wr(8'h64, 32'hf0);
    // alarm runs of 3 or 5, forcing, change flags
    for (int kind = 0; kind < 2; kind++) begin
      for (int sel = 0; sel < 2; sel++) begin
        need = sel ? 3 : 5;
        kc = kind ? K2_AIS_CODE : K2_RDI_CODE;
        wr(8'h60, sel ? 32'h10 << kind : 32'h40);
        repeat (need - 1) frame(kc, 8'h00, 4'h0);
        rd(8'h60);
        check(d[1:0], 2'b00, "alarm too early");
        frame(kc, 8'h00, 4'h0);
        check(irq, 1'b1, "irq on change");
        rd(8'h60);
        check(d[1:0], kind ? 2'b10 : 2'b01, "alarm state");
        rd(8'h64);
        check(d[3:0], kind ? 4'h2 : 4'h1, "change flag");
        repeat (3) @(posedge i_mclk);
        check(irq, 1'b0, "irq after clear");
        forced <= (kind == 1 && sel == 0);
        mon_on <= 1'b1;
        frame(kc, 8'h00, 4'h0);
        mon_on <= 1'b0;
        frame(3'h0, 8'h00, 4'h0);
        rd(8'h60);
        check(d[1:0], 2'b00, "alarm removed");
        rd(8'h64);
        check(d[3:0], kind ? 4'h2 : 4'h1, "flag on removal");
      end
    end
    // count and report modes, irq masks, polls
    for (int mode = 0; mode < 4; mode++) begin
      wr(8'h60, {24'h0, mode[0], 3'b000, mode[1], 3'b000});
      wr(8'h64, mode[1] ? 32'h00 : 32'hc0);
      wr(polls[mode], 32'h0);
      rd(8'h64);
      eb = 0;
      er = 0;
      ef = 0;
      base = rep_sum;
      for (int f = 0; f < 3; f++) begin
        rnd = lfsr(rnd);
        m8 = (f == 1) ? 8'h00 : ((f == 2) ? 8'hff : rnd[7:0] | 8'h10);
        frame(3'h0, m8, rnd[11:8]);
        eb += exp_b2(mode[0], m8);
        er += exp_b2(mode[1], m8);
        ef += exp_fe(rnd[11:8]);
      end
      check(irq, !mode[1], "error irq");
      rd(8'h64);
      check(d[3:0], {ef != 0, 3'b100}, "error flags");
      check(rep_sum - base, er, "reports");
      wr(polls[(mode + 1) % 4], 32'h0);
      for (int i = 0; i < 6; i++) begin
        rd(8'h68 + 8'(4 * i));
        cnt[i] = d[7:0];
      end
      check({cnt[2], cnt[1], cnt[0]}, eb, "b2 count");
      check({cnt[5], cnt[4], cnt[3]}, ef, "far end count");
    end
    end_of_test();
  end
endmodule // testbench

// ---- verilog/line_overhead_monitor.sv ----
// receive line overhead monitor: k2 alarms, all-ones forcing, b2 and
// far end error counters, interrupt flags, axi4-lite register slave
// assumes upstream marks k2, b2 and z2 bytes and gives b2 mismatch bits
`timescale 1ns/100ps
module line_overhead_monitor #(
  parameter int CNT_W = 20
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset,
  input  wire line_mon_pkg::line_in_t       i_line,
  output line_mon_pkg::line_out_t           o_line,
  output line_mon_pkg::febe_report_t        o_febe_rep,
  output logic                              o_irq,
  input  wire logic [line_mon_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                         i_awvalid,
  output logic                              o_awready,
  input  wire logic [31:0]                  i_wdata,
  input  wire logic [3:0]                   i_wstrb,
  input  wire logic                         i_wvalid,
  output logic                              o_wready,
  output logic [1:0]                        o_bresp,
  output logic                              o_bvalid,
  input  wire logic                         i_bready,
  input  wire logic [line_mon_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                         i_arvalid,
  output logic                              o_arready,
  output logic [31:0]                       o_rdata,
  output logic [1:0]                        o_rresp,
  output logic                              o_rvalid,
  input  wire logic                         i_rready
);
  import line_mon_pkg::*;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [3:0] popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] a,
                                               input logic [3:0]       b);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {{(CNT_W-3){1'b0}}, b};
    return s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
  endfunction

  function automatic logic [2:0] run_step(input logic [2:0] run, input logic hit);
    if (!hit) begin
      return 3'h0;
    end
    return (run == RUN_SLOW) ? run : run + 3'h1;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  ctrl_t              ctrl_r;
  logic [NFLAGS-1:0]  irq_en_r;
  logic [NFLAGS-1:0]  flags_r;
  logic [NFLAGS-1:0]  flags_nxt;
  logic               rdi_state_r;
  logic               ais_state_r;
  logic [2:0]         rdi_run_r;
  logic [2:0]         ais_run_r;
  logic               b2_seen_r;
  logic [CNT_W-1:0]   b2_acc_r;
  logic [CNT_W-1:0]   fe_acc_r;
  logic [CNT_W-1:0]   b2_hold_r;
  logic [CNT_W-1:0]   fe_hold_r;
  logic               aw_held_r;
  logic               w_held_r;
  logic               aw_rdy_r;
  logic               w_rdy_r;
  logic [IDX_W-1:0]   wr_idx_r;
  logic [7:0]         wr_byte_r;
  logic               wr_lane_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               ar_rdy_r;
  logic               rvalid_r;
  logic [1:0]         rresp_r;
  logic [7:0]         rdata_r;
  line_out_t          line_r;
  febe_report_t       rep_r;
  logic               irq_r;

  // ----------------------------------------------------------------------
  // k2 alarm detection
  // ----------------------------------------------------------------------
  wire logic [2:0] k2_code   = i_line.data[2:0];
  wire logic       k2_rdi    = i_line.k2_strobe && (k2_code == K2_RDI_CODE);
  wire logic       k2_ais    = i_line.k2_strobe && (k2_code == K2_AIS_CODE);
  wire logic [2:0] rdi_thr   = ctrl_r.remote_defect_detect_select ? RUN_FAST : RUN_SLOW;
  wire logic [2:0] ais_thr   = ctrl_r.alarm_indication_detect_select ? RUN_FAST : RUN_SLOW;
  wire logic [2:0] rdi_run_nxt = i_line.k2_strobe ? run_step(rdi_run_r, k2_rdi) : rdi_run_r;
  wire logic [2:0] ais_run_nxt = i_line.k2_strobe ? run_step(ais_run_r, k2_ais) : ais_run_r;
  // a single frame without the code removes the alarm
  wire logic rdi_nxt = i_line.k2_strobe ? (rdi_run_nxt >= rdi_thr) : rdi_state_r; // RULE_05
  wire logic ais_nxt = i_line.k2_strobe ? (ais_run_nxt >= ais_thr) : ais_state_r; // RULE_06

  // ----------------------------------------------------------------------
  // b2 and far end error events
  // ----------------------------------------------------------------------
  wire logic [3:0] b2_bits   = i_line.b2_strobe ? popcount(i_line.b2_mismatch) : 4'h0;
  wire logic       b2_hit    = (b2_bits != 4'h0);
  wire logic       b2_first  = b2_hit && (i_line.sof || !b2_seen_r);
  wire logic       b2_seen_nxt = i_line.sof ? b2_hit : (b2_seen_r || b2_hit);
  wire logic [3:0] b2_inc    = ctrl_r.b2_counting_mode ? {3'h0, b2_first} : b2_bits; // RULE_09
  // out-of-range z2 codes carry no error count
  wire logic [3:0] fe_code   = i_line.data[3:0];
  wire logic [3:0] fe_inc    = (i_line.z2_strobe && fe_code <= FEBE_MAX) ? fe_code : 4'h0;
  wire logic       fe_hit    = (fe_inc != 4'h0);

  // ----------------------------------------------------------------------
  // axi4-lite decode
  // ----------------------------------------------------------------------
  wire logic [IDX_W-1:0] ar_idx = i_araddr[ADDR_W-1:2];
  wire logic aw_take  = i_awvalid && aw_rdy_r;
  wire logic w_take   = i_wvalid && w_rdy_r;
  wire logic do_wr    = aw_held_r && w_held_r && !bvalid_r;
  wire logic ar_take  = i_arvalid && ar_rdy_r;
  wire logic wr_ctrl  = do_wr && wr_lane_r && (wr_idx_r == IDX_CTRL);
  wire logic wr_irq   = do_wr && wr_lane_r && (wr_idx_r == IDX_IRQ);
  wire logic wr_cnt   = do_wr && (wr_idx_r >= IDX_B2_LO) && (wr_idx_r <= IDX_FE_HI);
  wire logic poll     = wr_cnt || (do_wr && (wr_idx_r == IDX_MASTER)); // RULE_19 RULE_20
  wire logic wr_known = (wr_idx_r == IDX_MASTER) || ((wr_idx_r >= IDX_CTRL)
                        && (wr_idx_r <= IDX_FE_HI));
  wire logic rd_known = (ar_idx == IDX_MASTER) || ((ar_idx >= IDX_CTRL)
                        && (ar_idx <= IDX_FE_HI));
  wire logic rd_clr   = ar_take && (ar_idx == IDX_IRQ);
  wire logic [CNT_W+3:0] b2_wide = {4'h0, b2_hold_r};
  wire logic [CNT_W+3:0] fe_wide = {4'h0, fe_hold_r};

  logic [7:0] rd_byte;
  always_comb begin
    if (ar_idx == IDX_CTRL) begin
      rd_byte = {ctrl_r, 1'b0, ais_state_r, rdi_state_r}; // RULE_01 RULE_02
    end else if (ar_idx == IDX_IRQ) begin
      rd_byte = {irq_en_r, flags_r};
    end else if (ar_idx == IDX_B2_LO) begin
      rd_byte = b2_wide[7:0]; // RULE_18
    end else if (ar_idx == IDX_B2_MID) begin
      rd_byte = b2_wide[15:8];
    end else if (ar_idx == IDX_B2_HI) begin
      rd_byte = b2_wide[23:16];
    end else if (ar_idx == IDX_FE_LO) begin
      rd_byte = fe_wide[7:0]; // RULE_21
    end else if (ar_idx == IDX_FE_MID) begin
      rd_byte = fe_wide[15:8];
    end else if (ar_idx == IDX_FE_HI) begin
      rd_byte = fe_wide[23:16];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt flags: a set in the cycle of the clearing read wins
  // ----------------------------------------------------------------------
  logic [NFLAGS-1:0] flag_set;
  always_comb begin
    flag_set          = '0;
    flag_set[FLAG_RDI] = (rdi_nxt != rdi_state_r); // RULE_10
    flag_set[FLAG_AIS] = (ais_nxt != ais_state_r); // RULE_11
    flag_set[FLAG_B2]  = b2_hit;                   // RULE_12
    flag_set[FLAG_FE]  = fe_hit;                   // RULE_13
    flags_nxt = (rd_clr ? '0 : flags_r) | flag_set;
  end

  // enable gating per source, level output
  wire logic irq_nxt = |(flags_nxt & irq_en_r); // RULE_14 RULE_15 RULE_16 RULE_17 RULE_22

  // ----------------------------------------------------------------------
  // stream path and alarm state
  // ----------------------------------------------------------------------
  // forcing uses the same byte's alarm decision, so it is immediate
  wire logic force_now = ctrl_r.force_ones_on_alarm && ais_nxt; // RULE_07 RULE_08

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdi_state_r <= 1'b0;
      ais_state_r <= 1'b0;
      rdi_run_r   <= 3'h0;
      ais_run_r   <= 3'h0;
      b2_seen_r   <= 1'b0;
      line_r      <= '0;
    end else begin
      rdi_state_r <= rdi_nxt;
      ais_state_r <= ais_nxt;
      rdi_run_r   <= rdi_run_nxt;
      ais_run_r   <= ais_run_nxt;
      b2_seen_r   <= b2_seen_nxt;
      line_r.sof  <= i_line.sof;
      line_r.data <= force_now ? ALL_ONES : i_line.data;
    end
  end

  // ----------------------------------------------------------------------
  // error reports toward the transmit line unit
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rep_r <= '0;
    end else if (ctrl_r.outgoing_error_report_mode) begin
      rep_r.valid <= b2_first; // RULE_03
      rep_r.count <= {3'h0, b2_first};
    end else begin
      rep_r.valid <= b2_hit; // RULE_03
      rep_r.count <= b2_bits;
    end
  end

  // ----------------------------------------------------------------------
  // counters: the poll cycle's own event starts the new period
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      b2_acc_r  <= '0;
      fe_acc_r  <= '0;
      b2_hold_r <= '0;
      fe_hold_r <= '0;
    end else if (poll) begin
      b2_hold_r <= b2_acc_r; // RULE_19
      fe_hold_r <= fe_acc_r;
      b2_acc_r  <= sat_add('0, b2_inc); // RULE_04
      fe_acc_r  <= sat_add('0, fe_inc);
    end else begin
      b2_acc_r  <= sat_add(b2_acc_r, b2_inc); // RULE_04 RULE_09
      fe_acc_r  <= sat_add(fe_acc_r, fe_inc); // RULE_21
    end
  end

  // ----------------------------------------------------------------------
  // control and flag registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_r   <= '0;
      irq_en_r <= '0;
      flags_r  <= '0;
      irq_r    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wr_byte_r[7:3];
      end
      if (wr_irq) begin
        irq_en_r <= wr_byte_r[7:4];
      end
      flags_r <= flags_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_rdy_r  <= 1'b0;
      w_rdy_r   <= 1'b0;
      wr_idx_r  <= '0;
      wr_byte_r <= 8'h00;
      wr_lane_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        wr_idx_r <= i_awaddr[ADDR_W-1:2];
      end
      if (w_take) begin
        wr_byte_r <= i_wdata[7:0];
        wr_lane_r <= i_wstrb[0];
      end
      aw_held_r <= do_wr ? 1'b0 : (aw_held_r || aw_take);
      w_held_r  <= do_wr ? 1'b0 : (w_held_r || w_take);
      aw_rdy_r  <= !(aw_held_r || aw_take) || do_wr;
      w_rdy_r   <= !(w_held_r || w_take) || do_wr;
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel: one outstanding read, answer next cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 8'h00;
    end else if (ar_take) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= rd_byte;
    end else if (rvalid_r && i_rready) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
    end else begin
      ar_rdy_r <= !rvalid_r;
    end
  end

  assign o_line     = line_r;
  assign o_febe_rep = rep_r;
  assign o_irq      = irq_r;
  assign o_awready  = aw_rdy_r;
  assign o_wready   = w_rdy_r;
  assign o_bvalid   = bvalid_r;
  assign o_bresp    = bresp_r;
  assign o_arready  = ar_rdy_r;
  assign o_rvalid   = rvalid_r;
  assign o_rresp    = rresp_r;
  assign o_rdata    = {24'h000000, rdata_r};

endmodule // line_overhead_monitor
